/* File: hdl/one_wire_debug_port.sv */
// one-wire debugger: serial link, command decode, break and runtime counter
`timescale 1ns/10ps
module one_wire_debug_port
   import debug_port_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic debug_pin_in, // level seen on the debug pin
   output logic debug_pin_out, // value driven, always low when enabled
   output logic debug_pin_oe, // high while the pin is pulled low
   input wire logic read_protect_option, // flash read protect programmed
   input wire logic stop_mode, // processor is in stop mode
   input wire logic opcode_valid, // processor executes an opcode this cycle
   input wire logic [7:0] opcode, // opcode being executed
   output logic debug_mode, // debug_mode_bit, processor halted
   output logic break_taken, // one-cycle pulse, break entered debug
   output logic break_as_nop, // one-cycle pulse, break ran as no-op
   output logic system_reset_req, // request full reset; one cycle per control write with bit 1 set, held while the pin is low in stop mode
   output logic power_on_flag, // set with the reset requests below
   output logic [15:0] runtime_count, // runtime counter value
   output logic memory_readout_allowed // program memory may be read out
);
   // ==================================================
   // pin input synchroniser
   // ==================================================
   logic [2:0] pin_sync_r; // three stage synchroniser
   logic pin_level_r; // accepted pin level
   // the first stage only feeds the second; stages two and three must agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_sync_r <= 3'h7;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], debug_pin_in};
      end
   end
   // accept a new level once the later stages agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_level_r <= 1'b1;
      end else if (pin_sync_r[1] == pin_sync_r[2]) begin
         pin_level_r <= pin_sync_r[2];
      end
   end
   // ==================================================
   // receiver
   // ==================================================
   rx_state_t rx_state_r; // receiver state
   logic [15:0] rx_cnt_r; // bit timer
   logic [3:0] rx_bit_r; // data bit index
   logic [7:0] rx_shift_r; // incoming byte
   logic rx_valid; // byte complete pulse
   logic tx_busy; // transmitter is driving
   // sample at mid-bit; ignore the line while our own transmitter runs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_r <= RX_IDLE;
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_shift_r <= 8'h00;
      end else begin
         unique case (rx_state_r)
            RX_IDLE: begin
               if (!pin_level_r && !tx_busy) begin
                  rx_state_r <= RX_START;
                  rx_cnt_r <= HALF_BIT_CYCLES;
               end
            end
            RX_START: begin
               if (rx_cnt_r != 16'h0000) begin
                  rx_cnt_r <= rx_cnt_r - 16'h0001;
               end else if (pin_level_r) begin
                  rx_state_r <= RX_IDLE; // glitch, not a start bit
               end else begin
                  rx_state_r <= RX_DATA;
                  rx_cnt_r <= BIT_CYCLES - 16'h0001; // zero is the sample cycle
                  rx_bit_r <= 4'h0;
               end
            end
            RX_DATA: begin
               if (rx_cnt_r != 16'h0000) begin
                  rx_cnt_r <= rx_cnt_r - 16'h0001;
               end else begin
                  rx_shift_r <= {pin_level_r, rx_shift_r[7:1]};
                  rx_cnt_r <= BIT_CYCLES - 16'h0001; // one bit period per sample
                  rx_bit_r <= rx_bit_r + 4'h1;
                  if (rx_bit_r == DATA_BITS - 4'h1) begin
                     rx_state_r <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_cnt_r != 16'h0000) begin
                  rx_cnt_r <= rx_cnt_r - 16'h0001;
               end else begin
                  rx_state_r <= RX_IDLE; // framing error simply drops the byte
               end
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end
   // byte valid when stop bit sampled high
   assign rx_valid = (rx_state_r == RX_STOP) && (rx_cnt_r == 16'h0000) && pin_level_r;
   // ==================================================
   // two-entry answer buffer
   // ==================================================
   byte_t buf_mem_r [2]; // storage
   logic buf_wptr_r; // write index
   logic buf_rptr_r; // read index
   logic [1:0] buf_cnt_r; // occupancy
   logic buf_in_valid; // answer byte offered
   logic buf_in_ready; // space available
   byte_t buf_in_data; // answer byte
   logic buf_out_valid; // byte waiting for transmitter
   logic buf_out_ready; // transmitter takes the byte
   assign buf_in_ready = (buf_cnt_r != 2'h2);
   assign buf_out_valid = (buf_cnt_r != 2'h0);
   // push and pop the two entries
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         buf_wptr_r <= 1'b0;
         buf_rptr_r <= 1'b0;
         buf_cnt_r <= 2'h0;
         buf_mem_r[0] <= '0;
         buf_mem_r[1] <= '0;
      end else begin
         if (buf_in_valid && buf_in_ready) begin
            buf_mem_r[buf_wptr_r] <= buf_in_data;
            buf_wptr_r <= ~buf_wptr_r;
         end
         if (buf_out_valid && buf_out_ready) begin
            buf_rptr_r <= ~buf_rptr_r;
         end
         buf_cnt_r <= buf_cnt_r + 2'((buf_in_valid && buf_in_ready) ? 1 : 0)
                      - 2'((buf_out_valid && buf_out_ready) ? 1 : 0);
      end
   end
   // ==================================================
   // transmitter
   // ==================================================
   tx_state_t tx_state_r; // transmitter state
   logic [15:0] tx_cnt_r; // bit timer
   logic [3:0] tx_bit_r; // data bit index
   logic [7:0] tx_shift_r; // outgoing byte
   logic tx_low_r; // pull the pin low
   assign tx_busy = (tx_state_r != TX_IDLE);
   // stall the buffer while the host is sending or we are busy
   assign buf_out_ready = !tx_busy && (rx_state_r == RX_IDLE) && pin_level_r;
   // shift start, eight bits lsb first, stop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_r <= TX_IDLE;
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_shift_r <= 8'h00;
         tx_low_r <= 1'b0;
      end else begin
         unique case (tx_state_r)
            TX_IDLE: begin
               tx_low_r <= 1'b0;
               if (buf_out_valid && buf_out_ready) begin
                  tx_shift_r <= buf_mem_r[buf_rptr_r].data;
                  tx_state_r <= TX_START;
                  tx_cnt_r <= BIT_CYCLES;
                  tx_low_r <= 1'b1; // start bit low
               end
            end
            TX_START: begin
               if (tx_cnt_r != 16'h0001) begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end else begin
                  tx_state_r <= TX_DATA;
                  tx_cnt_r <= BIT_CYCLES;
                  tx_bit_r <= 4'h0;
                  tx_low_r <= ~tx_shift_r[0];
               end
            end
            TX_DATA: begin
               if (tx_cnt_r != 16'h0001) begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end else if (tx_bit_r == DATA_BITS - 4'h1) begin
                  tx_state_r <= TX_STOP;
                  tx_cnt_r <= BIT_CYCLES;
                  tx_low_r <= 1'b0; // stop bit high by release
               end else begin
                  tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                  tx_bit_r <= tx_bit_r + 4'h1;
                  tx_cnt_r <= BIT_CYCLES;
                  tx_low_r <= ~tx_shift_r[1];
               end
            end
            TX_STOP: begin
               if (tx_cnt_r != 16'h0001) begin
                  tx_cnt_r <= tx_cnt_r - 16'h0001;
               end else begin
                  tx_state_r <= TX_IDLE;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end
   // open drain: only ever drive low, otherwise release
   assign debug_pin_out = 1'b0;
   assign debug_pin_oe = tx_low_r;
   // ==================================================
   // command decoder
   // ==================================================
   cmd_state_t cm_state_r; // decoder state
   logic [7:0] ctrl_r; // debugger_control_reg
   logic [7:0] answer_r; // byte to queue
   logic [7:0] status_byte; // debugger status
   logic ctrl_wr; // control write accepted
   logic [7:0] ctrl_wr_data; // value being written
   logic mode_ok; // command allowed in this mode
   assign status_byte = {ctrl_r[CTRL_DEBUG_MODE_POS], 1'b0, read_protect_option,
                         5'h00};
   // queue answers only when buffer has room; host only ever leads
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cm_state_r <= CM_WAIT_CMD;
         answer_r <= 8'h00;
      end else begin
         unique case (cm_state_r)
            CM_WAIT_CMD: begin
               if (rx_valid) begin
                  unique case (rx_shift_r)
                     CMD_READ_REV: begin
                        answer_r <= REVISION_VALUE;
                        cm_state_r <= CM_SEND_ONE;
                     end
                     CMD_READ_STATUS: begin
                        answer_r <= status_byte;
                        cm_state_r <= CM_SEND_ONE;
                     end
                     CMD_READ_RUNTIME: begin
                        if (mode_ok) begin
                           cm_state_r <= CM_SEND_HI;
                        end
                     end
                     CMD_WRITE_CTRL: cm_state_r <= CM_WAIT_ARG;
                     CMD_READ_CTRL: begin
                        answer_r <= ctrl_r;
                        cm_state_r <= CM_SEND_ONE;
                     end
                     default: cm_state_r <= CM_WAIT_CMD;
                  endcase
               end
            end
            CM_WAIT_ARG: begin
               if (rx_valid) begin
                  cm_state_r <= CM_WAIT_CMD;
               end
            end
            CM_SEND_HI: begin
               if (buf_in_ready) begin
                  cm_state_r <= CM_SEND_LO;
               end
            end
            CM_SEND_LO, CM_SEND_ONE: begin
               if (buf_in_ready) begin
                  cm_state_r <= CM_WAIT_CMD;
               end
            end
            default: cm_state_r <= CM_WAIT_CMD;
         endcase
      end
   end
   // runtime read needs debug mode; read protect leaves it allowed
   assign mode_ok = ctrl_r[CTRL_DEBUG_MODE_POS];
   // answer byte offered to the buffer
   always_comb begin
      buf_in_valid = 1'b0;
      buf_in_data.data = answer_r;
      unique case (cm_state_r)
         CM_SEND_HI: begin
            buf_in_valid = 1'b1;
            buf_in_data.data = runtime_count[15:8];
         end
         CM_SEND_LO: begin
            buf_in_valid = 1'b1;
            buf_in_data.data = runtime_count[7:0];
         end
         CM_SEND_ONE: buf_in_valid = 1'b1;
         default: buf_in_valid = 1'b0;
      endcase
   end
   // control write: protection keeps the debug mode bit from clearing
   assign ctrl_wr = (cm_state_r == CM_WAIT_ARG) && rx_valid;
   always_comb begin
      ctrl_wr_data = rx_shift_r;
      if (read_protect_option && ctrl_r[CTRL_DEBUG_MODE_POS]) begin
         ctrl_wr_data[CTRL_DEBUG_MODE_POS] = 1'b1;
      end
   end
   // ==================================================
   // control register, break handling
   // ==================================================
   logic brk_hit; // break opcode executed
   assign brk_hit = opcode_valid && (opcode == BREAK_OPCODE)
                    && !ctrl_r[CTRL_DEBUG_MODE_POS];
   // break entry wins over a host write that arrives the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RESET_VALUE;
      end else begin
         if (ctrl_wr) begin
            ctrl_r <= ctrl_wr_data;
            ctrl_r[CTRL_RESET_POS] <= 1'b0; // reset bit acts once
         end
         if (brk_hit && !ctrl_r[CTRL_BRK_SUPPRESS_POS]) begin
            ctrl_r[CTRL_DEBUG_MODE_POS] <= 1'b1;
         end
      end
   end
   // break event pulses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         break_taken <= 1'b0;
         break_as_nop <= 1'b0;
      end else begin
         break_taken <= brk_hit && !ctrl_r[CTRL_BRK_SUPPRESS_POS];
         break_as_nop <= brk_hit && ctrl_r[CTRL_BRK_SUPPRESS_POS];
      end
   end
   assign debug_mode = ctrl_r[CTRL_DEBUG_MODE_POS];
   // protected parts never stream code out
   assign memory_readout_allowed = !read_protect_option && ctrl_r[CTRL_DEBUG_MODE_POS];
   // ==================================================
   // reset requests
   // ==================================================
   // control bit 1 or pin low in stop mode ask for a full reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         system_reset_req <= 1'b0;
         power_on_flag <= 1'b0;
      end else begin
         system_reset_req <= (ctrl_wr && ctrl_wr_data[CTRL_RESET_POS])
                             || (stop_mode && !pin_level_r);
         if ((ctrl_wr && ctrl_wr_data[CTRL_RESET_POS]) || (stop_mode && !pin_level_r)) begin
            power_on_flag <= 1'b1;
         end
      end
   end
   // ==================================================
   // runtime counter
   // ==================================================
   logic [15:0] runtime_r; // cycles since leaving debug
   logic was_debug_r; // debug mode last cycle
   // restart on leaving debug, hold in debug, saturate at the top
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         runtime_r <= 16'h0000;
         was_debug_r <= 1'b0;
      end else begin
         was_debug_r <= ctrl_r[CTRL_DEBUG_MODE_POS];
         if (was_debug_r && !ctrl_r[CTRL_DEBUG_MODE_POS]) begin
            runtime_r <= 16'h0000;
         end else if (!ctrl_r[CTRL_DEBUG_MODE_POS] && runtime_r != RUNTIME_MAX) begin
            runtime_r <= runtime_r + 16'h0001;
         end
      end
   end
   assign runtime_count = runtime_r;
endmodule : one_wire_debug_port

/* File: common/debug_port_pkg.sv */
// package of constants and carriers for the one-wire debug port
package debug_port_pkg;
   // ==================================================
   // clock and serial timing
   // ==================================================
   localparam int unsigned CLK_HZ = 125000000; // system clock rate
   localparam int unsigned BAUD_HZ = 115200; // default link bit rate
   localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_HZ); // cycles per bit
   localparam logic [15:0] HALF_BIT_CYCLES = 16'(CLK_HZ / BAUD_HZ / 2); // mid-bit point
   localparam logic [3:0] DATA_BITS = 4'h8; // data bits per frame
   // ==================================================
   // command bytes
   // ==================================================
   localparam logic [7:0] CMD_READ_REV = 8'h00; // revision read
   localparam logic [7:0] CMD_RESERVED = 8'h01; // no defined function
   localparam logic [7:0] CMD_READ_STATUS = 8'h02; // status read
   localparam logic [7:0] CMD_READ_RUNTIME = 8'h03; // runtime counter read
   localparam logic [7:0] CMD_WRITE_CTRL = 8'h04; // control write
   localparam logic [7:0] CMD_READ_CTRL = 8'h05; // control read
   localparam logic [7:0] BREAK_OPCODE = 8'h00; // break instruction opcode
   // ==================================================
   // control register layout and reset values
   // ==================================================
   localparam int unsigned CTRL_DEBUG_MODE_POS = 7; // debug_mode_bit position
   localparam int unsigned CTRL_BRK_SUPPRESS_POS = 6; // break suppression position
   localparam int unsigned CTRL_RESET_POS = 1; // self-clearing reset request
   localparam logic [7:0] CTRL_RESET_VALUE = 8'h00; // control value after reset
   localparam logic [15:0] RUNTIME_MAX = 16'hffff; // saturation value
   localparam logic [7:0] REVISION_VALUE = 8'h5a; // arbitrary revision code
   // ==================================================
   // carriers
   // ==================================================
   typedef struct packed {
      logic [7:0] data; // byte carried
   } byte_t;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_STOP
   } rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_STOP
   } tx_state_t;
   typedef enum logic [2:0] {
      CM_WAIT_CMD, CM_WAIT_ARG, CM_SEND_HI, CM_SEND_LO, CM_SEND_ONE
   } cmd_state_t;
endpackage : debug_port_pkg

/* File: test/debug_port_properties.sv */
// concurrent checks on the pins of the one-wire debug port
`timescale 1ns/10ps
module debug_port_properties
   import debug_port_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic debug_pin_in,
   input wire logic debug_pin_out,
   input wire logic debug_pin_oe,
   input wire logic read_protect_option,
   input wire logic stop_mode,
   input wire logic opcode_valid,
   input wire logic [7:0] opcode,
   input wire logic debug_mode,
   input wire logic break_taken,
   input wire logic break_as_nop,
   input wire logic system_reset_req,
   input wire logic power_on_flag,
   input wire logic [15:0] runtime_count,
   input wire logic memory_readout_allowed
);
   // ==================================================
   // helper: length of the current pulled-low run
   // ==================================================
   logic [15:0] oe_run_r; // cycles the device has held the pin low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oe_run_r <= 16'h0000;
      end else if (debug_pin_oe) begin
         oe_run_r <= oe_run_r + 16'h0001;
      end else begin
         oe_run_r <= 16'h0000;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ==================================================
   // assertions
   // ==================================================
   pin_low_only_a: assert property (debug_pin_out == 1'b0)
      else $error("debug pin driven high");
   reply_when_idle_a: assert property ($rose(debug_pin_oe) |->
      $past(debug_pin_in) && $past(debug_pin_in, 2) && $past(debug_pin_in, 3))
      else $error("reply started on a busy pin");
   bit_length_a: assert property ($fell(debug_pin_oe) |->
      oe_run_r != 16'h0000 && oe_run_r % BIT_CYCLES == 16'h0000)
      else $error("low run not a whole number of bits");
   break_enters_a: assert property (break_taken |-> debug_mode &&
      !$past(debug_mode) && $past(opcode_valid && opcode == BREAK_OPCODE))
      else $error("break pulse without a break opcode");
   break_nop_a: assert property (break_as_nop |-> !debug_mode &&
      $past(opcode_valid && opcode == BREAK_OPCODE))
      else $error("suppressed break entered debug");
   runtime_counts_a: assert property (($past(reset_n) && !debug_mode &&
      !$past(debug_mode) && !$past(debug_mode, 2) && !$past(debug_mode, 3) &&
      $past(runtime_count) != RUNTIME_MAX) |-> runtime_count == $past(runtime_count) + 16'h0001)
      else $error("runtime counter missed a cycle");
   runtime_frozen_a: assert property ((debug_mode && $past(debug_mode)) |->
      $stable(runtime_count)) else $error("runtime counter moved in debug mode");
   stop_pin_reset_a: assert property (($fell(debug_pin_in) && stop_mode) ##1
      (stop_mode && !debug_pin_in) [*4] |-> ##[0:8] system_reset_req)
      else $error("no reset for pin low in stop mode");
   reset_flag_a: assert property (system_reset_req |-> ##[0:1] power_on_flag)
      else $error("reset request without power-on flag");
   readout_gate_a: assert property (memory_readout_allowed ==
      (debug_mode && !read_protect_option)) else $error("readout gate wrong");
endmodule : debug_port_properties

bind one_wire_debug_port debug_port_properties u_props (
   .clk(clk), .reset_n(reset_n), .debug_pin_in(debug_pin_in),
   .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
   .read_protect_option(read_protect_option), .stop_mode(stop_mode),
   .opcode_valid(opcode_valid), .opcode(opcode), .debug_mode(debug_mode),
   .break_taken(break_taken), .break_as_nop(break_as_nop),
   .system_reset_req(system_reset_req), .power_on_flag(power_on_flag),
   .runtime_count(runtime_count), .memory_readout_allowed(memory_readout_allowed));

/* File: test/host_model.sv */
// host end of the one-wire debug link, pulling the pin low only
`timescale 1ns/10ps
module host_model
   import debug_port_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic pin, // resolved pin level, pulled up
   output logic host_oe // high while the host pulls the pin low
);
   initial host_oe = 1'b0;
   // hold one level for n cycles; high means released to the pull-up
   task automatic send_bit(input logic v, input logic [15:0] n);
      host_oe <= ~v;
      repeat (n) @(posedge clk);
   endtask : send_bit
   // one frame; stop is cut short so the reply start is not missed
   task automatic send_byte(input logic [7:0] b);
      int i;
      i = 0;
      while (pin !== 1'b1 && i < 4 * BIT_CYCLES) begin
         @(posedge clk);
         i++;
      end
      @(posedge clk);
      send_bit(1'b0, BIT_CYCLES);
      for (i = 0; i < 8; i++) send_bit(b[i], BIT_CYCLES);
      send_bit(1'b1, 16'd300);
   endtask : send_byte
   // wait up to limit cycles for a start, then sample mid-bit
   task automatic recv_byte(input int limit, output logic [7:0] b, output logic ok);
      int i;
      b = 8'h00;
      ok = 1'b0;
      i = 0;
      while (pin !== 1'b0 && i < limit) begin
         @(negedge clk);
         i++;
      end
      if (pin === 1'b0) begin
         repeat (HALF_BIT_CYCLES) @(negedge clk);
         ok = (pin === 1'b0);
         for (i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge clk);
            b[i] = pin;
         end
         repeat (BIT_CYCLES) @(negedge clk);
         ok = ok && (pin === 1'b1);
      end
   endtask : recv_byte
   // hold the pin low outside any frame
   task automatic pull_low(input int n);
      @(posedge clk);
      host_oe <= 1'b1;
      repeat (n) @(posedge clk);
      host_oe <= 1'b0;
   endtask : pull_low
endmodule : host_model

/* File: test/testbench.sv */
// self-checking bench of the one-wire debug port against a small model
`timescale 1ns/10ps
module testbench
   import debug_port_pkg::*;
;
   logic clk, reset_n, read_protect_option, stop_mode, opcode_valid, host_oe;
   logic [7:0] opcode, ctl, b;
   logic debug_pin_out, debug_pin_oe, debug_mode, break_taken, break_as_nop, ok;
   logic system_reset_req, power_on_flag, memory_readout_allowed, m_dbg, m_sup;
   logic [15:0] runtime_count, r0;
   int mismatches, n_checks, cycles, m_rt, n_rst, seed;
   wire pin_level = !(debug_pin_oe || host_oe); // pull-up unless pulled low
   one_wire_debug_port DUT (.clk(clk), .reset_n(reset_n), .debug_pin_in(pin_level),
      .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
      .read_protect_option(read_protect_option), .stop_mode(stop_mode),
      .opcode_valid(opcode_valid), .opcode(opcode), .debug_mode(debug_mode),
      .break_taken(break_taken), .break_as_nop(break_as_nop),
      .system_reset_req(system_reset_req), .power_on_flag(power_on_flag),
      .runtime_count(runtime_count), .memory_readout_allowed(memory_readout_allowed));
   host_model host (.clk(clk), .pin(pin_level), .host_oe(host_oe));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==================================================
   // reference model: debug state and runtime counter
   // ==================================================
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         m_rt <= 0;
         m_dbg <= 1'b0;
      end else begin
         if (!m_dbg && m_rt < 65535) m_rt <= m_rt + 1;
         if (opcode_valid && opcode == BREAK_OPCODE && !m_dbg && !m_sup) m_dbg <= 1'b1;
      end
   end
   // cycle ceiling and reset-request tally
   always @(posedge clk) begin
      cycles++;
      if (system_reset_req === 1'b1) n_rst++;
      if (cycles == 100000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // command, then n reply bytes, high byte first
   task automatic exchange(input logic [7:0] cmd, input int n, input logic [15:0] exp);
      int k;
      host.send_byte(cmd);
      for (k = n - 1; k >= 0; k--) begin
         host.recv_byte(BIT_CYCLES, b, ok);
         check("reply byte", {8'h01, exp[k*8 +: 8]}, {7'h00, ok, b});
      end
      repeat (BIT_CYCLES) @(posedge clk);
   endtask : exchange
   // break into debug by a one-cycle pulse on the opcode port
   task automatic run_break();
      @(posedge clk);
      opcode_valid <= 1'b1;
      opcode <= BREAK_OPCODE;
      @(posedge clk);
      opcode_valid <= 1'b0;
      @(negedge clk);
   endtask : run_break
   initial begin
      seed = 48;
      {reset_n, read_protect_option, stop_mode, opcode_valid, m_sup} = 5'h00;
      opcode = 8'h00;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (10) begin
         @(posedge clk);
         opcode_valid <= 1'b1;
         opcode <= 8'($random(seed)) | 8'h01;
      end
      run_break();
      check("break taken", 16'h1, {15'h0, break_taken});
      check("debug mode", {15'h0, m_dbg}, {15'h0, debug_mode});
      @(posedge clk);
      read_protect_option <= 1'b1;
      @(negedge clk);
      check("readout", 16'h0, {15'h0, memory_readout_allowed});
      @(posedge clk);
      read_protect_option <= 1'b0;
      @(negedge clk);
      check("readout", 16'h1, {15'h0, memory_readout_allowed});
      exchange(CMD_READ_RUNTIME, 2, 16'(m_rt));
      ctl = {2'b01, 6'($random(seed))} | 8'h02;
      m_sup = ctl[6];
      host.send_byte(CMD_WRITE_CTRL);
      repeat (BIT_CYCLES) @(posedge clk);
      host.send_byte(ctl);
      repeat (BIT_CYCLES) @(negedge clk);
      check("debug mode", 16'h0, {15'h0, debug_mode});
      check("reset requests", 16'h1, 16'(n_rst));
      check("power-on flag", 16'h1, {15'h0, power_on_flag});
      r0 = runtime_count;
      repeat (20) @(negedge clk);
      check("runtime", r0 + 16'd20, runtime_count);
      check("runtime restart", 16'h1, {15'h0, runtime_count < BIT_CYCLES});
      host.send_byte(CMD_READ_RUNTIME);
      host.recv_byte(2 * BIT_CYCLES, b, ok);
      check("refused reply", 16'h0, {15'h0, ok});
      exchange(CMD_READ_CTRL, 1, {8'h00, ctl & 8'hfd});
      run_break();
      check("break as nop", 16'h1, {15'h0, break_as_nop});
      check("debug mode", 16'h0, {15'h0, debug_mode});
      @(posedge clk);
      stop_mode <= 1'b1;
      host.pull_low(12);
      repeat (8) @(posedge clk);
      check("stop reset", 16'h1, {15'h0, n_rst >= 2});
      stop_mode <= 1'b0;
      tally_and_finish();
   end
endmodule : testbench
